// [rtl/cdh_params.svh]
// cdh constants: field positions, addresses and timing counts
// Contract
// [RL1] input_ack_n only on own selected io read
// [RL2] host gates input buffers with input_ack_n
// [RL3] single-socket host may ignore input_ack_n
// [RL4] request when ready to move data
// [RL5] strobe choice sets multiword direction; the card takes it from dma_read_dir instead
// [RL6] hold request until acknowledge, then drop
// [RL7] host ignores request during io read
// [RL8] no io read while request asserted
// [RL9] ide request undriven when drive unselected
// [RL10] selects negated during dma, 16-bit words
// [RL11] drive read data while read strobe low
// [RL12] ide read strobe behaves as io mode
// [RL13] host_dma_ready high accepts read bursts
// [RL14] ready low pauses device data-in
// [RL15] capture word on every strobe edge
// [RL16] no strobe edges, no data taken
// [RL17] task file uses low byte only; the card masks reads to it in ide mode only, io mode reads carry all 16 bits
// [RL18] stop on write line ends burst
// [RL19] request active low, high in ide
`ifndef CDH_PARAMS_SVH
`define CDH_PARAMS_SVH

`define CDH_WORD_W 16
`define CDH_BYTE_W 8
`define CDH_FIFO_DEPTH 8
`define CDH_ADDR_W 3
`define CDH_STATUS_ADDR 3'h7
`define CDH_DRVHEAD_ADDR 3'h6
`define CDH_DRV_BIT 4

// positions in the device's synchroniser vector
`define CDH_SY_RD 0
`define CDH_SY_WR 1
`define CDH_SY_ACK 2
`define CDH_SY_HRDY 3
`define CDH_SY_HSTB 4
`define CDH_SY_SEL 5
`define CDH_SY_UDMA 6
`define CDH_SY_M0 7
`define CDH_SY_M1 8
`define CDH_SY_N 9
// read and write strobes and select idle high, everything else low
`define CDH_SY_IDLE 9'h023

// positions in the host's synchroniser vector
`define CDH_HY_REQ 0
`define CDH_HY_ACK 1
`define CDH_HY_DSTB 2
`define CDH_HY_N 3

// timing
`define CDH_CORE_NS 20
`define CDH_STROBE_NS 400
`define CDH_STROBE_CYC ((`CDH_STROBE_NS + `CDH_CORE_NS - 1) / `CDH_CORE_NS)
`define CDH_CNT_W 5
`define CDH_UDMA_PACE 3'h7

`endif

// [rtl/cdh_pkg.sv]
// cdh types shared by both ends
package cdh_pkg;
	typedef enum logic [1:0] {CDH_MODE_MEM, CDH_MODE_IO, CDH_MODE_IDE} cdh_mode_t;
	typedef enum logic [2:0] {
		CDH_CMD_IO_READ, CDH_CMD_DMA_READ, CDH_CMD_DMA_WRITE,
		CDH_CMD_UDMA_READ, CDH_CMD_UDMA_WRITE
	} cdh_cmd_t;
	typedef enum logic [2:0] {D_IDLE, D_REQ, D_MW, D_UIN, D_UOUT} cdh_dev_state_t;
	typedef enum logic [3:0] {
		H_IDLE, H_IOWAIT, H_IO_READ_STROBE_N, H_DREQ, H_DACK, H_DXFER, H_DEND, H_UIN, H_UOUT, H_GAP
	} cdh_host_state_t;
endpackage

// [rtl/cdh_link_if.sv]
// cdh link between host adapter and card
`timescale 1ns/1ns
`default_nettype none
`include "cdh_params.svh"
interface cdh_link_if;
	logic link_clk;
	cdh_pkg::cdh_mode_t card_mode;
	logic udma_on;
	logic taskfile_select_n;
	logic ctrl_reg_select_n;
	logic io_read_strobe_n;
	logic io_write_strobe_n;
	logic dma_acknowledge;
	logic host_dma_ready;
	logic host_data_strobe;
	logic [`CDH_ADDR_W-1:0] addr;
	logic [`CDH_WORD_W-1:0] host_data_o;
	logic host_data_oe;
	logic [`CDH_WORD_W-1:0] dev_data_o;
	logic dev_data_oe;
	logic [`CDH_WORD_W-1:0] data;
	logic dma_req_o;
	logic dma_req_oe;
	logic dma_request;
	logic input_ack_n;
	logic dev_data_strobe;

	// bus resolution; an undriven request line is pulled to its ide idle level
	assign data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 16'h0000);
	assign dma_request = dma_req_oe ? dma_req_o : 1'b0;

	modport device(
		input link_clk, card_mode, udma_on, taskfile_select_n, ctrl_reg_select_n,
		input io_read_strobe_n, io_write_strobe_n, dma_acknowledge, host_dma_ready,
		input host_data_strobe, addr, data,
		output dev_data_o, dev_data_oe, dma_req_o, dma_req_oe, input_ack_n, dev_data_strobe
	);
	modport host(
		output link_clk, card_mode, udma_on, taskfile_select_n, ctrl_reg_select_n,
		output io_read_strobe_n, io_write_strobe_n, dma_acknowledge, host_dma_ready,
		output host_data_strobe, addr, host_data_o, host_data_oe,
		input data, dma_request, input_ack_n, dev_data_strobe
	);
endinterface
`default_nettype wire

// [rtl/cdh_device.sv]
// cdh card end: request, acknowledge and read strobe handling with its tx fifo
`timescale 1ns/1ns
`default_nettype none
`include "cdh_params.svh"

////////////////////////////////////////////////////////////////////////////////
// word fifo between the card's user side and the link
module cdh_fifo #(
	parameter int WIDTH = `CDH_WORD_W,
	parameter int DEPTH = `CDH_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} cdh_fifo_reg_t;
	cdh_fifo_reg_t st;
	cdh_fifo_reg_t next_st;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	// full and empty come from the count, so neither can lie
	assign in_ready = st.cnt != (AW+1)'(DEPTH);
	assign out_valid = st.cnt != '0;
	assign out_data = st.mem[st.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer and count update
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = bump(st.wp);
		end
		if (pop) begin
			next_st.rp = bump(st.rp);
		end
		next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// card end, clocked by the link clock
module cdh_device (
	cdh_link_if.device lnk,
	input wire logic rst,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [`CDH_WORD_W-1:0] tx_data,
	input wire logic dma_read_dir,
	input wire logic want_data,
	input wire logic own_drive,
	input wire logic [`CDH_WORD_W-1:0] status_word,
	output logic [`CDH_WORD_W-1:0] rx_data,
	output logic rx_valid,
	output logic busy
);
	typedef struct packed {
		logic [`CDH_SY_N-1:0] s1;
		logic [`CDH_SY_N-1:0] s2;
		logic [`CDH_SY_N-1:0] prev;
		cdh_pkg::cdh_dev_state_t state;
		logic req_on;
		logic [`CDH_WORD_W-1:0] data_out;
		logic data_oe;
		logic inack;
		logic dstb;
		logic [2:0] pace;
		logic drv;
		logic [`CDH_WORD_W-1:0] rx_data;
		logic rx_valid;
	} cdh_dev_reg_t;
	cdh_dev_reg_t st;
	cdh_dev_reg_t next_st;
	logic [`CDH_SY_N-1:0] raw;
	logic fifo_valid;
	logic [`CDH_WORD_W-1:0] fifo_data;
	logic pop;
	cdh_pkg::cdh_mode_t mode;
	logic rd_low;
	logic sel;
	logic ack;
	logic stop;
	logic udma;
	logic more;
	logic pio;

	function automatic logic rise(input logic p, input logic c);
		return !p && c;
	endfunction

	cdh_fifo #(.WIDTH(`CDH_WORD_W), .DEPTH(`CDH_FIFO_DEPTH)) u_fifo (
		.clk(lnk.link_clk),
		.rst(rst),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);

	// host mode, select, strobe and handshake levels arrive from the other clock, so they pass two flops
	assign raw = {lnk.card_mode, lnk.udma_on, lnk.taskfile_select_n, lnk.host_data_strobe,
		lnk.host_dma_ready, lnk.dma_acknowledge, lnk.io_write_strobe_n, lnk.io_read_strobe_n};
	assign mode = cdh_pkg::cdh_mode_t'(st.s2[`CDH_SY_M1:`CDH_SY_M0]);
	assign rd_low = !st.s2[`CDH_SY_RD];
	assign sel = !st.s2[`CDH_SY_SEL];
	assign ack = st.s2[`CDH_SY_ACK];
	assign stop = st.s2[`CDH_SY_WR];
	assign udma = st.s2[`CDH_SY_UDMA];
	assign more = dma_read_dir ? fifo_valid : want_data;
	// address and data are held steady by the host across a strobe, so they are read direct
	assign pio = st.state == cdh_pkg::D_IDLE && !udma && mode != cdh_pkg::CDH_MODE_MEM && sel
		&& rd_low && lnk.addr == `CDH_STATUS_ADDR; // [RL12]

	// pin drive; request polarity follows the mode
	assign lnk.dma_req_o = (mode == cdh_pkg::CDH_MODE_IDE) ? st.req_on : !st.req_on; // [RL19]
	assign lnk.dma_req_oe = mode != cdh_pkg::CDH_MODE_IDE || st.drv == own_drive; // [RL9]
	assign lnk.dev_data_o = st.data_out;
	assign lnk.dev_data_oe = st.data_oe;
	assign lnk.input_ack_n = !st.inack;
	assign lnk.dev_data_strobe = st.dstb;
	assign rx_data = st.rx_data;
	assign rx_valid = st.rx_valid;
	assign busy = st.state != cdh_pkg::D_IDLE;

	// handshake engine
	always_comb begin
		next_st = st;
		next_st.s1 = raw;
		next_st.s2 = st.s1;
		next_st.prev = st.s2;
		next_st.rx_valid = 1'b0;
		next_st.data_oe = 1'b0;
		next_st.inack = 1'b0;
		pop = 1'b0;
		// drive select is caught from the drive/head write in ide mode
		if (mode == cdh_pkg::CDH_MODE_IDE && sel && lnk.addr == `CDH_DRVHEAD_ADDR
			&& rise(st.prev[`CDH_SY_WR], st.s2[`CDH_SY_WR])) begin
			next_st.drv = lnk.data[`CDH_DRV_BIT]; // [RL17]
		end
		case (st.state)
		cdh_pkg::D_IDLE: begin
			if (pio) begin
				// task file reads in ide only carry the low byte
				next_st.data_out = (mode == cdh_pkg::CDH_MODE_IDE) ?
					{8'h00, status_word[`CDH_BYTE_W-1:0]} : status_word; // [RL17]
				next_st.data_oe = 1'b1; // [RL11]
				next_st.inack = mode == cdh_pkg::CDH_MODE_IO; // [RL1]
			end else if (more && !ack) begin
				// a new request waits for the last acknowledge to drop
				next_st.req_on = 1'b1; // [RL4]
				next_st.state = cdh_pkg::D_REQ;
			end
		end
		cdh_pkg::D_REQ: begin
			// request stays up until the acknowledge arrives
			if (ack) begin
				next_st.req_on = 1'b0; // [RL6]
				next_st.pace = '0;
				if (!udma) begin
					next_st.state = cdh_pkg::D_MW;
				end else if (dma_read_dir) begin
					next_st.state = cdh_pkg::D_UIN;
				end else begin
					next_st.state = cdh_pkg::D_UOUT;
				end
			end
		end
		cdh_pkg::D_MW: begin
			// direction follows dma_read_dir, not the strobe the host moves
			if (!ack) begin
				next_st.state = cdh_pkg::D_IDLE; // [RL6]
			end else if (dma_read_dir) begin
				if (rd_low) begin
					next_st.data_out = fifo_data; // [RL5]
					next_st.data_oe = 1'b1; // [RL11]
				end
				pop = rise(st.prev[`CDH_SY_RD], st.s2[`CDH_SY_RD]) && fifo_valid;
			end else if (rise(st.prev[`CDH_SY_WR], st.s2[`CDH_SY_WR])) begin
				next_st.rx_data = lnk.data; // [RL5]
				next_st.rx_valid = 1'b1;
			end
		end
		cdh_pkg::D_UIN: begin
			if (stop || !ack) begin
				next_st.state = cdh_pkg::D_IDLE; // [RL18]
			end else begin
				next_st.data_oe = 1'b1;
				if (st.pace != '0) begin
					next_st.pace = st.pace - 3'h1;
				end else if (st.s2[`CDH_SY_HRDY] && fifo_valid) begin // [RL14]
					// spacing leaves the host's synchroniser time to see each edge
					next_st.data_out = fifo_data;
					next_st.dstb = !st.dstb;
					next_st.pace = `CDH_UDMA_PACE;
					pop = 1'b1;
				end
			end
		end
		cdh_pkg::D_UOUT: begin
			if (stop || !ack) begin
				next_st.state = cdh_pkg::D_IDLE; // [RL18]
			end else if (st.s2[`CDH_SY_HSTB] != st.prev[`CDH_SY_HSTB]) begin // [RL16]
				next_st.rx_data = lnk.data; // [RL15]
				next_st.rx_valid = 1'b1;
			end
		end
		default: begin
			next_st.state = cdh_pkg::D_IDLE;
		end
		endcase
	end

	always_ff @(posedge lnk.link_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			// synchronisers start at the idle levels so no false edge follows reset
			st.s1 <= `CDH_SY_IDLE;
			st.s2 <= `CDH_SY_IDLE;
			st.prev <= `CDH_SY_IDLE;
		end else begin
			st <= next_st;
		end
	end
endmodule
`default_nettype wire

// [rtl/cdh_host.sv]
// cdh host end: io reads, multiword and ultra dma word transfers
`timescale 1ns/1ns
`default_nettype none
`include "cdh_params.svh"
module cdh_host (
	input wire logic core_clk,
	input wire logic rst,
	cdh_link_if.host lnk,
	input wire cdh_pkg::cdh_mode_t card_mode,
	input wire logic single_socket,
	input wire logic pause,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire cdh_pkg::cdh_cmd_t cmd_kind,
	input wire logic [`CDH_ADDR_W-1:0] cmd_addr,
	input wire logic [`CDH_WORD_W-1:0] cmd_wdata,
	output logic [`CDH_WORD_W-1:0] rsp_data,
	output logic rsp_valid
);
	localparam logic [`CDH_CNT_W-1:0] STROBE = `CDH_CNT_W'(`CDH_STROBE_CYC);
	typedef struct packed {
		logic lclk;
		logic [`CDH_HY_N-1:0] s1;
		logic [`CDH_HY_N-1:0] s2;
		logic [`CDH_HY_N-1:0] prev;
		cdh_pkg::cdh_host_state_t state;
		logic [`CDH_CNT_W-1:0] cnt;
		cdh_pkg::cdh_cmd_t kind;
		cdh_pkg::cdh_mode_t mode;
		logic udma;
		logic tf_n;
		logic rd_n;
		logic wr_n;
		logic ack;
		logic hrdy;
		logic hstb;
		logic sent;
		logic [`CDH_ADDR_W-1:0] addr;
		logic [`CDH_WORD_W-1:0] data_o;
		logic data_oe;
		logic [`CDH_WORD_W-1:0] rsp_data;
		logic rsp_valid;
	} cdh_host_reg_t;
	cdh_host_reg_t st;
	cdh_host_reg_t next_st;
	logic req_act;
	logic done;

	// the link clock is core clock divided by two and driven out
	assign lnk.link_clk = st.lclk;
	assign lnk.card_mode = st.mode;
	assign lnk.udma_on = st.udma;
	assign lnk.taskfile_select_n = st.tf_n;
	assign lnk.ctrl_reg_select_n = 1'b1; // [RL10]
	assign lnk.io_read_strobe_n = st.rd_n;
	assign lnk.io_write_strobe_n = st.wr_n;
	assign lnk.dma_acknowledge = st.ack;
	assign lnk.host_dma_ready = st.hrdy;
	assign lnk.host_data_strobe = st.hstb;
	assign lnk.addr = st.addr;
	assign lnk.host_data_o = st.data_o;
	assign lnk.host_data_oe = st.data_oe;
	assign cmd_ready = st.state == cdh_pkg::H_IDLE;
	assign rsp_data = st.rsp_data;
	assign rsp_valid = st.rsp_valid;
	// request level read through the synchroniser, polarity by mode
	assign req_act = (st.mode == cdh_pkg::CDH_MODE_IDE) ? st.s2[`CDH_HY_REQ] : !st.s2[`CDH_HY_REQ];
	assign done = st.cnt == '0;

	// command sequencer
	always_comb begin
		next_st = st;
		next_st.lclk = !st.lclk;
		next_st.s1 = {lnk.dev_data_strobe, lnk.input_ack_n, lnk.dma_request};
		next_st.s2 = st.s1;
		next_st.prev = st.s2;
		next_st.rsp_valid = 1'b0;
		if (!done) begin
			next_st.cnt = st.cnt - `CDH_CNT_W'(1);
		end
		case (st.state)
		cdh_pkg::H_IDLE: begin
			next_st.mode = card_mode;
			if (cmd_valid) begin
				next_st.kind = cmd_kind;
				next_st.addr = cmd_addr;
				next_st.data_o = cmd_wdata;
				next_st.cnt = STROBE;
				next_st.udma = cmd_kind == cdh_pkg::CDH_CMD_UDMA_READ
					|| cmd_kind == cdh_pkg::CDH_CMD_UDMA_WRITE;
				next_st.state = (cmd_kind == cdh_pkg::CDH_CMD_IO_READ) ?
					cdh_pkg::H_IOWAIT : cdh_pkg::H_DREQ;
			end
		end
		cdh_pkg::H_IOWAIT: begin
			// an io read never starts over a pending request
			if (done && !req_act) begin // [RL8]
				next_st.tf_n = 1'b0;
				next_st.rd_n = 1'b0;
				next_st.cnt = STROBE;
				next_st.state = cdh_pkg::H_IO_READ_STROBE_N;
			end
		end
		cdh_pkg::H_IO_READ_STROBE_N: begin
			// request changes during the read are not looked at here
			if (done) begin // [RL7]
				next_st.rsp_data = (single_socket || !st.s2[`CDH_HY_ACK]) ? lnk.data : '0; // [RL2] [RL3]
				next_st.rsp_valid = 1'b1;
				next_st.rd_n = 1'b1;
				next_st.tf_n = 1'b1;
				next_st.cnt = STROBE;
				next_st.state = cdh_pkg::H_GAP;
			end
		end
		cdh_pkg::H_DREQ: begin
			// selects stay negated for the whole dma sequence
			if (done && req_act) begin // [RL10]
				next_st.ack = 1'b1; // [RL6]
				next_st.cnt = STROBE;
				if (st.kind == cdh_pkg::CDH_CMD_UDMA_READ) begin
					next_st.wr_n = 1'b0;
					next_st.state = cdh_pkg::H_UIN;
				end else if (st.kind == cdh_pkg::CDH_CMD_UDMA_WRITE) begin
					next_st.wr_n = 1'b0;
					next_st.data_oe = 1'b1;
					next_st.sent = 1'b0;
					next_st.state = cdh_pkg::H_UOUT;
				end else begin
					next_st.state = cdh_pkg::H_DACK;
				end
			end
		end
		cdh_pkg::H_DACK: begin
			if (done) begin
				if (st.kind == cdh_pkg::CDH_CMD_DMA_READ) begin
					next_st.rd_n = 1'b0; // [RL5]
				end else begin
					next_st.wr_n = 1'b0; // [RL5]
					next_st.data_oe = 1'b1;
				end
				next_st.cnt = STROBE;
				next_st.state = cdh_pkg::H_DXFER;
			end
		end
		cdh_pkg::H_DXFER: begin
			if (done) begin
				if (st.kind == cdh_pkg::CDH_CMD_DMA_READ) begin
					next_st.rsp_data = lnk.data;
					next_st.rsp_valid = 1'b1;
				end
				next_st.rd_n = 1'b1;
				next_st.wr_n = 1'b1;
				next_st.cnt = STROBE;
				next_st.state = cdh_pkg::H_DEND;
			end
		end
		cdh_pkg::H_UIN: begin
			next_st.hrdy = !pause; // [RL13] [RL14]
			if (st.s2[`CDH_HY_DSTB] != st.prev[`CDH_HY_DSTB]) begin
				next_st.rsp_data = lnk.data;
				next_st.rsp_valid = 1'b1;
				next_st.hrdy = 1'b0;
				next_st.wr_n = 1'b1; // [RL18]
				next_st.cnt = STROBE;
				next_st.state = cdh_pkg::H_DEND;
			end
		end
		cdh_pkg::H_UOUT: begin
			// a paused host just holds the strobe level
			if (done && !st.sent && !pause) begin // [RL16]
				next_st.hstb = !st.hstb; // [RL15]
				next_st.sent = 1'b1;
				next_st.cnt = STROBE;
			end else if (done && st.sent) begin
				next_st.wr_n = 1'b1; // [RL18]
				next_st.cnt = STROBE;
				next_st.state = cdh_pkg::H_DEND;
			end
		end
		cdh_pkg::H_DEND: begin
			// acknowledge outlasts the strobe so the card sees the last edge first
			if (done) begin
				next_st.ack = 1'b0;
				next_st.data_oe = 1'b0;
				next_st.cnt = STROBE;
				next_st.state = cdh_pkg::H_GAP;
			end
		end
		cdh_pkg::H_GAP: begin
			next_st.udma = 1'b0;
			if (done) begin
				next_st.state = cdh_pkg::H_IDLE;
			end
		end
		default: begin
			next_st.state = cdh_pkg::H_IDLE;
		end
		endcase
	end

	// read and write strobes and the task file select idle high
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
			st.tf_n <= 1'b1;
			st.rd_n <= 1'b1;
			st.wr_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end
endmodule
`default_nettype wire

// [bench/cdh_link_properties.sv]
// cdh link checker: handshake and strobe relations seen on the shared link
`timescale 1ns/1ns
`default_nettype none
`include "cdh_params.svh"
module cdh_link_properties (
	input wire logic link_clk,
	input wire logic rst,
	input wire cdh_pkg::cdh_mode_t card_mode,
	input wire logic udma_on,
	input wire logic taskfile_select_n,
	input wire logic ctrl_reg_select_n,
	input wire logic io_read_strobe_n,
	input wire logic io_write_strobe_n,
	input wire logic dma_acknowledge,
	input wire logic host_dma_ready,
	input wire logic [`CDH_ADDR_W-1:0] addr,
	input wire logic dev_data_oe,
	input wire logic dma_request,
	input wire logic dma_req_oe,
	input wire logic input_ack_n,
	input wire logic dev_data_strobe
);
	logic [2:0] age;
	cdh_pkg::cdh_mode_t last_mode;
	logic settled;
	logic req_act;
	default clocking @(posedge link_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	// the card sees the mode through a synchroniser, so judge the request only once it settled
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			age <= 3'h0;
			last_mode <= cdh_pkg::CDH_MODE_MEM;
		end else begin
			last_mode <= card_mode;
			age <= (card_mode != last_mode) ? 3'h0 : ((age == 3'h7) ? age : age + 3'h1);
		end
	end
	// request as the card means it: low in mem and io, high in ide
	assign settled = (age == 3'h7) && (card_mode == last_mode);
	assign req_act = (card_mode == cdh_pkg::CDH_MODE_IDE) ? dma_request : !dma_request;
	input_ack_n_own_read_a: assert property ($fell(input_ack_n) |->
		card_mode == cdh_pkg::CDH_MODE_IO && !taskfile_select_n && !io_read_strobe_n
		&& addr == `CDH_STATUS_ADDR) else $error("input ack without own io read");
	req_driven_a: assert property (settled && card_mode != cdh_pkg::CDH_MODE_IDE |->
		dma_req_oe) else $error("request line left undriven outside ide");
	req_hold_a: assert property (settled && req_act && !dma_acknowledge |=> req_act)
		else $error("request dropped before acknowledge");
	req_drop_a: assert property (settled && $rose(dma_acknowledge) |-> ##[1:6] !req_act)
		else $error("request kept after acknowledge");
	ack_no_select_a: assert property (dma_acknowledge |->
		taskfile_select_n && ctrl_reg_select_n) else $error("select low during dma");
	mw_one_dir_a: assert property (dma_acknowledge && !udma_on |->
		io_read_strobe_n || io_write_strobe_n) else $error("both strobes low in dma");
	rd_gates_data_a: assert property ($rose(dev_data_oe) && !udma_on |->
		!io_read_strobe_n) else $error("card drives data without read strobe");
	rd_drives_data_a: assert property ($fell(io_read_strobe_n) && !udma_on && settled
		&& card_mode != cdh_pkg::CDH_MODE_MEM |-> ##[2:6] dev_data_oe)
		else $error("card silent on read strobe");
	host_no_read_a: assert property (settled && $fell(taskfile_select_n) |-> !req_act)
		else $error("io read started under a pending request");
	ready_pause_a: assert property (udma_on && !host_dma_ready [*4] |->
		$stable(dev_data_strobe)) else $error("data-in sent while host not ready");
	stop_ends_a: assert property (udma_on && dma_acknowledge && io_write_strobe_n [*4] |->
		$stable(dev_data_strobe)) else $error("burst runs on after stop");
	cover property ($rose(dma_acknowledge) && !udma_on);
	cover property ($fell(input_ack_n));
	cover property (udma_on && $changed(dev_data_strobe));
	cover property (settled && !dma_req_oe);
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// cdh bench: host and card joined on one link, both user sides driven here
`timescale 1ns/1ns
`default_nettype none
`include "cdh_params.svh"
module tb_top;
	logic core_clk, rst, single_socket, pause, cmd_valid, cmd_ready, rsp_valid, seen_ack;
	cdh_pkg::cdh_mode_t card_mode;
	cdh_pkg::cdh_cmd_t cmd_kind;
	logic [2:0] cmd_addr;
	logic [15:0] cmd_wdata, rsp_data, tx_data, status_word, rx_data, rx_last;
	logic tx_valid, tx_ready, dma_read_dir, want_data, own_drive, rx_valid, busy;
	int n_errors, comparisons, rx_count;
	cdh_link_if lnk();
	cdh_host cdh_host_inst (.core_clk(core_clk), .rst(rst), .lnk(lnk), .card_mode(card_mode),
		.single_socket(single_socket), .pause(pause), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .rsp_data(rsp_data), .rsp_valid(rsp_valid));
	cdh_device cdh_device_inst (.lnk(lnk), .rst(rst), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .dma_read_dir(dma_read_dir), .want_data(want_data),
		.own_drive(own_drive), .status_word(status_word), .rx_data(rx_data),
		.rx_valid(rx_valid), .busy(busy));
	cdh_link_properties cdh_link_properties_inst (.link_clk(lnk.link_clk), .rst(rst),
		.card_mode(lnk.card_mode), .udma_on(lnk.udma_on),
		.taskfile_select_n(lnk.taskfile_select_n), .ctrl_reg_select_n(lnk.ctrl_reg_select_n),
		.io_read_strobe_n(lnk.io_read_strobe_n), .io_write_strobe_n(lnk.io_write_strobe_n),
		.dma_acknowledge(lnk.dma_acknowledge), .host_dma_ready(lnk.host_dma_ready),
		.addr(lnk.addr), .dev_data_oe(lnk.dev_data_oe), .dma_request(lnk.dma_request),
		.dma_req_oe(lnk.dma_req_oe), .input_ack_n(lnk.input_ack_n),
		.dev_data_strobe(lnk.dev_data_strobe));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// card-side observers; the link clock only runs once the host leaves reset
	always @(posedge lnk.link_clk) begin
		if (rx_valid === 1'b1) rx_count <= rx_count + 1;
		if (rx_valid === 1'b1) rx_last <= rx_data;
		if (lnk.input_ack_n === 1'b0) seen_ack <= 1'b1;
	end
	////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic give_up(input string what);
		n_errors++;
		$display("Error %s expected done seen timeout", what);
		tally_and_finish();
	endtask
	task automatic wait_link(input int n);
		repeat (n) @(posedge lnk.link_clk);
	endtask
	// mode is only taken while the host is idle; give the card's synchroniser time
	task automatic set_mode(input cdh_pkg::cdh_mode_t m, input logic ss);
		int i;
		for (i = 0; i < 400; i++) begin
			@(posedge core_clk);
			if (cmd_ready === 1'b1) break;
		end
		if (i == 400) give_up("set_mode");
		card_mode <= m;
		single_socket <= ss;
		wait_link(12);
	endtask
	// hold the command until the edge that sees cmd_ready high
	task automatic host_cmd(input cdh_pkg::cdh_cmd_t k, input logic [15:0] w);
		int i;
		logic ok;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_addr <= `CDH_STATUS_ADDR;
		cmd_wdata <= w;
		for (i = 0; i < 4000; i++) begin
			@(negedge core_clk);
			ok = cmd_ready;
			@(posedge core_clk);
			if (ok === 1'b1) break;
		end
		cmd_valid <= 1'b0;
		if (i == 4000) give_up("cmd_ready");
	endtask
	task automatic wait_rsp(input logic [15:0] exp, input string what);
		int i;
		for (i = 0; i < 4000; i++) begin
			@(negedge core_clk);
			if (rsp_valid === 1'b1) break;
		end
		if (i == 4000) give_up(what);
		check(what, rsp_data, exp);
	endtask
	// want_data drops at once so the card does not ask for a second word
	task automatic wait_rx(input int n, input logic [15:0] exp, input string what);
		int i;
		for (i = 0; i < 500; i++) begin
			@(posedge lnk.link_clk);
			if (rx_count > n) break;
		end
		want_data <= 1'b0;
		if (i == 500) give_up(what);
		check(what, rx_last, exp);
	endtask
	task automatic push(input logic [15:0] w);
		int i;
		logic ok;
		@(posedge lnk.link_clk);
		tx_valid <= 1'b1;
		tx_data <= w;
		for (i = 0; i < 100; i++) begin
			@(negedge lnk.link_clk);
			ok = tx_ready;
			@(posedge lnk.link_clk);
			if (ok === 1'b1) break;
		end
		tx_valid <= 1'b0;
		if (i == 100) give_up("tx_ready");
	endtask
	////////////////////////////////////////////////////////////
	// io reads in memory mode go unanswered, in io mode the card acknowledges
	task automatic t_io_reads();
		host_cmd(cdh_pkg::CDH_CMD_IO_READ, 16'h0000);
		wait_rsp(16'h0000, "mem_read");
		check("mem_ack", seen_ack, 1'b0);
		set_mode(cdh_pkg::CDH_MODE_IO, 1'b0);
		host_cmd(cdh_pkg::CDH_CMD_IO_READ, 16'h0000);
		wait_rsp(16'h5a3c, "io_read");
		check("io_ack", seen_ack, 1'b1);
	endtask
	// fill the fifo until it refuses, then drain it word by word over multiword dma
	task automatic t_dma_fifo();
		int k;
		check("req_idle", lnk.dma_request, 1'b1);
		for (k = 0; k < 8; k++) push(16'h1000 + 16'(k));
		@(negedge lnk.link_clk);
		check("fifo_full", tx_ready, 1'b0);
		check("req_low", lnk.dma_request, 1'b0);
		check("busy_req", busy, 1'b1);
		for (k = 0; k < 8; k++) begin
			host_cmd(cdh_pkg::CDH_CMD_DMA_READ, 16'h0000);
			wait_rsp(16'h1000 + 16'(k), "dma_read");
		end
		wait_link(20);
		check("req_done", lnk.dma_request, 1'b1);
		check("busy_idle", busy, 1'b0);
	endtask
	task automatic t_writes();
		int n;
		@(posedge lnk.link_clk);
		dma_read_dir <= 1'b0;
		want_data <= 1'b1;
		n = rx_count;
		host_cmd(cdh_pkg::CDH_CMD_DMA_WRITE, 16'ha55a);
		wait_rx(n, 16'ha55a, "dma_write");
		@(posedge core_clk);
		pause <= 1'b1;
		want_data <= 1'b1;
		n = rx_count;
		host_cmd(cdh_pkg::CDH_CMD_UDMA_WRITE, 16'hc3c3);
		wait_link(60);
		check("udma_held", 16'(rx_count - n), 16'h0000);
		@(posedge core_clk);
		pause <= 1'b0;
		wait_rx(n, 16'hc3c3, "udma_write");
		wait_link(40);
		check("udma_words", 16'(rx_count - n), 16'h0001);
	endtask
	task automatic t_udma_read();
		logic stb;
		@(posedge lnk.link_clk);
		dma_read_dir <= 1'b1;
		push(16'h0f0f);
		@(posedge core_clk);
		pause <= 1'b1;
		stb = lnk.dev_data_strobe;
		host_cmd(cdh_pkg::CDH_CMD_UDMA_READ, 16'h0000);
		wait_link(60);
		check("udma_stall", lnk.dev_data_strobe, stb);
		@(posedge core_clk);
		pause <= 1'b0;
		wait_rsp(16'h0f0f, "udma_read");
	endtask
	// ide: request undriven for another drive, active high for ours, low byte reads
	task automatic t_ide();
		set_mode(cdh_pkg::CDH_MODE_IDE, 1'b1);
		@(posedge lnk.link_clk);
		own_drive <= 1'b1;
		push(16'h7e81);
		wait_link(8);
		check("req_oe", lnk.dma_req_oe, 1'b0);
		@(posedge lnk.link_clk);
		own_drive <= 1'b0;
		wait_link(8);
		check("req_high", lnk.dma_request, 1'b1);
		host_cmd(cdh_pkg::CDH_CMD_DMA_READ, 16'h0000);
		wait_rsp(16'h7e81, "ide_dma");
		seen_ack = 1'b0;
		host_cmd(cdh_pkg::CDH_CMD_IO_READ, 16'h0000);
		wait_rsp(16'h003c, "ide_read");
		check("ide_ack", seen_ack, 1'b0);
	endtask
	initial begin
		{rst, seen_ack} = 2'b00;
		{single_socket, pause, cmd_valid, tx_valid, want_data, own_drive} = 6'h00;
		card_mode = cdh_pkg::CDH_MODE_MEM;
		cmd_kind = cdh_pkg::CDH_CMD_IO_READ;
		cmd_addr = '0;
		{cmd_wdata, tx_data, rx_count, n_errors, comparisons} = '0;
		dma_read_dir = 1'b1;
		status_word = 16'h5a3c;
		// raised by nba so every reset process is already waiting for the edge
		rst <= 1'b1;
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		wait_link(4);
		t_io_reads();
		t_dma_fifo();
		t_writes();
		t_udma_read();
		t_ide();
		tally_and_finish();
	end
endmodule
`default_nettype wire
